// ---- rtl/event_notifier_pkg.sv ----
// package: constants and types for the camera event notifier
package event_notifier_pkg;

  localparam int NUM_EVENTS = 9;
  localparam int TS_WIDTH = 64;

  // event type codes, as held in the selector
  typedef enum logic [3:0] {
    EV_ACCEPTED = 4'h0,
    EV_REJECTED = 4'h1,
    EV_WAITING = 4'h2,
    EV_XFER_BEGIN = 4'h3,
    EV_XFER_FINISH = 4'h4,
    EV_EXPOSE_BEGIN = 4'h5,
    EV_EXPOSE_FINISH = 4'h6,
    EV_TIMER_BEGIN = 4'h7,
    EV_TIMER_FINISH = 4'h8
  } event_type_type;

  // event identifiers sent in the packet
  localparam logic [15:0] ID_ACCEPTED = 16'h8020;
  localparam logic [15:0] ID_REJECTED = 16'h8021;
  localparam logic [15:0] ID_WAITING = 16'h8022;
  localparam logic [15:0] ID_XFER_BEGIN = 16'h8030;
  localparam logic [15:0] ID_XFER_FINISH = 16'h8031;
  localparam logic [15:0] ID_EXPOSE_BEGIN = 16'h8040;
  localparam logic [15:0] ID_EXPOSE_FINISH = 16'h8041;
  localparam logic [15:0] ID_TIMER_BEGIN = 16'h9000;
  localparam logic [15:0] ID_TIMER_FINISH = 16'h9100;

  // register word offsets (byte addresses)
  localparam logic [7:0] OFS_SELECT = 8'h00;
  localparam logic [7:0] OFS_NOTIFY = 8'h04;
  localparam logic [7:0] OFS_TIME_LO = 8'h08;
  localparam logic [7:0] OFS_TIME_HI = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;
  localparam logic [7:0] OFS_DROP_STATUS = 8'h1c;

  // reset values, and the value read at unmapped addresses
  localparam logic [3:0] RST_SELECT = 4'h0;
  localparam logic [8:0] RST_NOTIFY = 9'h000;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

  // packet sender states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01
  } send_state_type;

endpackage

// ---- rtl/event_packet_sender.sv ----
// one-entry packet sender: hands event id and timestamp to the link with valid/ready
`timescale 1ns/1ps
`default_nettype none
module event_packet_sender
  import event_notifier_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic req_valid, // event waiting to be sent
  input wire logic [15:0] req_id, // event identifier
  input wire logic [TS_WIDTH-1:0] req_time, // event timestamp
  output logic req_taken, // pulse: request accepted
  output logic pkt_valid_ff, // packet offered to the link
  output logic [15:0] pkt_id_ff, // packet event identifier
  output logic [TS_WIDTH-1:0] pkt_time_ff, // packet timestamp
  input wire logic pkt_ready // link accepts packet
);
  send_state_type state_ff;

  // take a request when idle
  assign req_taken = (state_ff == ST_IDLE) && req_valid;

  // hold the packet until the link takes it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      pkt_valid_ff <= 1'b0;
      pkt_id_ff <= 16'h0000;
      pkt_time_ff <= '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (req_valid) begin
            state_ff <= ST_SEND;
            pkt_valid_ff <= 1'b1;
            pkt_id_ff <= req_id;
            pkt_time_ff <= req_time;
          end
        end
        ST_SEND: begin
          if (pkt_ready) begin
            state_ff <= ST_IDLE;
            pkt_valid_ff <= 1'b0;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          pkt_valid_ff <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- rtl/camera_event_notifier.sv ----
// camera event notifier: event capture, timestamps, notify enables, packet requests
//
// Summary of operation
// - an enabled event is sent as an event packet to the host, unless one of its type is still pending (the two merge)
// - accepted frame start trigger raises event id 0x8020
// - rejected frame start trigger raises event id 0x8021
// - beginning to wait for frame start trigger raises event id 0x8022
// - start of streaming data transfer raises event id 0x8030
// - end of streaming data transfer raises event id 0x8031
// - exposure start raises event id 0x8040
// - exposure end raises event id 0x8041
// - first timer start raises event id 0x9000
// - first timer end raises event id 0x9100
// - host picks event type by selector first; selector resets to frame accepted
// - per selected type an on/off notify setting, off at reset, gates packets
// - each event type latches the timestamp of its last occurrence, readable
`timescale 1ns/1ps
`default_nettype none
module camera_event_notifier
  import event_notifier_pkg::*;
(
  input wire logic clk, // system clock, 100 MHz
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [TS_WIDTH-1:0] timestamp, // free-running camera time
  input wire logic frame_start_accepted, // pulse: trigger accepted
  input wire logic frame_start_rejected, // pulse: trigger discarded
  input wire logic frame_start_waiting, // pulse: waiting for trigger begins
  input wire logic xfer_begin, // pulse: stream transfer starts
  input wire logic xfer_finish, // pulse: stream transfer ends
  input wire logic expose_begin, // pulse: exposure starts
  input wire logic expose_finish, // pulse: exposure ends
  input wire logic first_timer_begin, // pulse: timer output starts
  input wire logic first_timer_finish, // pulse: timer output ends
  input wire logic [7:0] avs_address, // avalon byte address
  input wire logic avs_read, // avalon read
  input wire logic avs_write, // avalon write
  input wire logic [31:0] avs_writedata, // avalon write data
  input wire logic [3:0] avs_byteenable, // avalon byte enables
  output logic [31:0] avs_readdata, // avalon read data
  output logic avs_waitrequest, // avalon wait request
  output logic evt_pkt_valid, // event packet offered
  output logic [15:0] evt_pkt_id, // event packet identifier
  output logic [TS_WIDTH-1:0] evt_pkt_time, // event packet timestamp
  input wire logic evt_pkt_ready, // link takes event packet
  output logic irq // interrupt, high while an enabled status bit is set
);
  // identifier table in event type order
  localparam logic [15:0] ID_TABLE [NUM_EVENTS] = '{
    ID_ACCEPTED,
    ID_REJECTED,
    ID_WAITING,
    ID_XFER_BEGIN,
    ID_XFER_FINISH,
    ID_EXPOSE_BEGIN,
    ID_EXPOSE_FINISH,
    ID_TIMER_BEGIN,
    ID_TIMER_FINISH
  };

  // registers
  logic [3:0] event_type_select_ff;
  logic [NUM_EVENTS-1:0] notify_enable_ff;
  logic [TS_WIDTH-1:0] event_time_ff [NUM_EVENTS];
  logic [NUM_EVENTS-1:0] pending_ff;
  logic [NUM_EVENTS-1:0] irq_status_ff;
  logic [NUM_EVENTS-1:0] irq_enable_ff;
  logic [NUM_EVENTS-1:0] drop_status_ff;
  logic [31:0] time_hi_shadow_ff;
  logic [31:0] readdata_ff;
  logic waitrequest_ff;
  logic irq_ff;

  // event gather and packet grant
  logic [NUM_EVENTS-1:0] ev_in;
  logic [3:0] grant_idx;
  logic grant_any;
  logic req_taken;
  logic [NUM_EVENTS-1:0] taken_vec;

  // bus decode
  logic hit_select;
  logic hit_notify;
  logic hit_time_lo;
  logic hit_time_hi;
  logic hit_status;
  logic hit_clear;
  logic hit_enable;
  logic hit_drop;
  logic wr_ok;
  logic wr_sel;
  logic wr_notify;
  logic wr_clear;
  logic wr_enable;
  logic wr_drop;
  logic bus_req;
  logic sel_valid;
  logic [NUM_EVENTS-1:0] lane_en;
  logic [31:0] nxt_readdata;

  // event inputs gathered in type order
  assign ev_in = {first_timer_finish,
                  first_timer_begin,
                  expose_finish,
                  expose_begin,
                  xfer_finish,
                  xfer_begin,
                  frame_start_waiting,
                  frame_start_rejected,
                  frame_start_accepted};

  // address decode shared by the write strobes and the read mux
  assign hit_select = (avs_address == OFS_SELECT);
  assign hit_notify = (avs_address == OFS_NOTIFY);
  assign hit_time_lo = (avs_address == OFS_TIME_LO);
  assign hit_time_hi = (avs_address == OFS_TIME_HI);
  assign hit_status = (avs_address == OFS_IRQ_STATUS);
  assign hit_clear = (avs_address == OFS_IRQ_CLEAR);
  assign hit_enable = (avs_address == OFS_IRQ_ENABLE);
  assign hit_drop = (avs_address == OFS_DROP_STATUS);

  // bus write strobes, taken on the cycle waitrequest is low
  assign bus_req = (avs_read || avs_write) && !waitrequest_ff;
  assign wr_ok = avs_write && !waitrequest_ff;
  assign wr_sel = wr_ok && hit_select;
  assign wr_notify = wr_ok && hit_notify;
  assign wr_clear = wr_ok && hit_clear;
  assign wr_enable = wr_ok && hit_enable;
  assign wr_drop = wr_ok && hit_drop;

  // selector names one of the nine types
  assign sel_valid = (event_type_select_ff < 4'(NUM_EVENTS));

  // waitrequest: one wait cycle per access, read data ready at the release edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waitrequest_ff <= 1'b1;
    end else if (bus_req) begin
      waitrequest_ff <= 1'b1;
    end else begin
      waitrequest_ff <= !(avs_read || avs_write);
    end
  end

  // event type selector, starts at frame accepted
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      event_type_select_ff <= RST_SELECT;
    end else if (wr_sel && avs_byteenable[0] && (avs_writedata[3:0] < 4'(NUM_EVENTS))) begin
      event_type_select_ff <= avs_writedata[3:0];
    end
  end

  // per type notify enables; only the selected one is written
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      notify_enable_ff <= RST_NOTIFY;
    end else if (wr_notify && avs_byteenable[0] && sel_valid) begin
      notify_enable_ff[event_type_select_ff] <= avs_writedata[0];
    end
  end

  // per type logic: timestamp latch, pending packet request, sticky status
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_event
      // timestamp of last occurrence
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          event_time_ff[gi] <= '0;
        end else if (ev_in[gi]) begin
          event_time_ff[gi] <= timestamp;
        end
      end

      // pending packet: set by enabled event, cleared when sender takes it
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          pending_ff[gi] <= 1'b0;
        end else if (ev_in[gi] && notify_enable_ff[gi]) begin
          pending_ff[gi] <= 1'b1;
        end else if (!notify_enable_ff[gi]) begin
          pending_ff[gi] <= 1'b0;
        end else if (taken_vec[gi]) begin
          pending_ff[gi] <= 1'b0;
        end
      end

      // overrun: enabled event arrived while its previous packet still pending
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          drop_status_ff[gi] <= 1'b0;
        end else if (ev_in[gi] && notify_enable_ff[gi] && pending_ff[gi] && !taken_vec[gi]) begin
          drop_status_ff[gi] <= 1'b1;
        end else if (wr_drop && lane_en[gi] && avs_writedata[gi]) begin
          drop_status_ff[gi] <= 1'b0;
        end
      end

      // sticky interrupt status, set wins over clear
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          irq_status_ff[gi] <= 1'b0;
        end else if (ev_in[gi]) begin
          irq_status_ff[gi] <= 1'b1;
        end else if (wr_clear && lane_en[gi] && avs_writedata[gi]) begin
          irq_status_ff[gi] <= 1'b0;
        end
      end

      // byte lane that carries this bit on a write
      assign lane_en[gi] = avs_byteenable[gi / 8];

      // grant of this type to the sender
      assign taken_vec[gi] = req_taken && (grant_idx == 4'(gi));
    end
  endgenerate

  // fixed priority: lowest type code goes first
  always_comb begin
    grant_idx = 4'h0;
    grant_any = 1'b0;
    for (int i = NUM_EVENTS - 1; i >= 0; i--) begin
      if (pending_ff[i]) begin
        grant_idx = 4'(i);
        grant_any = 1'b1;
      end
    end
  end

  // packet sender to the event channel
  event_packet_sender u_sender (
    .clk(clk),
    .rst_n(rst_n),
    .req_valid(grant_any),
    .req_id(ID_TABLE[grant_idx]),
    .req_time(event_time_ff[grant_idx]),
    .req_taken(req_taken),
    .pkt_valid_ff(evt_pkt_valid),
    .pkt_id_ff(evt_pkt_id),
    .pkt_time_ff(evt_pkt_time),
    .pkt_ready(evt_pkt_ready)
  );

  // interrupt enable register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_enable_ff <= '0;
    end else if (wr_enable) begin
      irq_enable_ff <= (irq_enable_ff & ~lane_en) | (avs_writedata[NUM_EVENTS-1:0] & lane_en);
    end
  end

  // level interrupt from a flip-flop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_status_ff & irq_enable_ff);
    end
  end

  // read mux, address decode
  always_comb begin
    nxt_readdata = UNMAPPED_READ;
    if (hit_select) begin
      nxt_readdata = {28'h0000000, event_type_select_ff};
    end else if (hit_notify) begin
      nxt_readdata = {31'h00000000, sel_valid && notify_enable_ff[event_type_select_ff]};
    end else if (hit_time_lo) begin
      nxt_readdata = event_time_ff[event_type_select_ff][31:0];
    end else if (hit_time_hi) begin
      nxt_readdata = time_hi_shadow_ff;
    end else if (hit_status) begin
      nxt_readdata = {23'h000000, irq_status_ff};
    end else if (hit_enable) begin
      nxt_readdata = {23'h000000, irq_enable_ff};
    end else if (hit_drop) begin
      nxt_readdata = {23'h000000, drop_status_ff};
    end
  end

  // read data registered in the wait cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      readdata_ff <= 32'h00000000;
    end else if (avs_read && waitrequest_ff) begin
      readdata_ff <= nxt_readdata;
    end
  end

  // high word caught with the low word, so a low-then-high pair reads one timestamp
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      time_hi_shadow_ff <= 32'h00000000;
    end else if (avs_read && waitrequest_ff && hit_time_lo) begin
      time_hi_shadow_ff <= event_time_ff[event_type_select_ff][63:32];
    end
  end

  // outputs straight from their flip-flops
  assign avs_readdata = readdata_ff;
  assign avs_waitrequest = waitrequest_ff;
  assign irq = irq_ff;
endmodule
`default_nettype wire

// ---- tb/host_link_model.sv ----
// host side model: takes event packets, may stall, keeps the last one
`timescale 1ns/1ps
`default_nettype none
module host_link_model
  import event_notifier_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic stall, // bench holds the host off
  input wire logic evt_pkt_valid, // packet offered
  input wire logic [15:0] evt_pkt_id, // packet id
  input wire logic [TS_WIDTH-1:0] evt_pkt_time, // packet time
  output logic evt_pkt_ready, // host takes packet
  output logic [7:0] got_count_ff, // packets taken
  output logic [15:0] got_id_ff, // last id taken
  output logic [TS_WIDTH-1:0] got_time_ff // last time taken
);
  // ready is the inverse of stall, one cycle late; a packet counts only at a valid and ready edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      evt_pkt_ready <= 1'b0;
      got_count_ff <= 8'h00;
    end else begin
      evt_pkt_ready <= !stall;
      if (evt_pkt_valid && evt_pkt_ready) begin
        got_count_ff <= got_count_ff + 8'h01;
        got_id_ff <= evt_pkt_id;
        got_time_ff <= evt_pkt_time;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/camera_event_notifier_sva.sv ----
// checker: port assertions for the camera event notifier
`timescale 1ns/1ps
`default_nettype none
module camera_event_notifier_sva
  import event_notifier_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic [7:0] avs_address, // address
  input wire logic avs_read, // read
  input wire logic avs_write, // write
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // wait
  input wire logic evt_pkt_valid, // packet offered
  input wire logic [15:0] evt_pkt_id, // packet id
  input wire logic [TS_WIDTH-1:0] evt_pkt_time, // packet time
  input wire logic evt_pkt_ready // link takes packet
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // packet stands unchanged until taken, then drops
  property p_hold;
    evt_pkt_valid && !evt_pkt_ready |=>
      evt_pkt_valid && $stable(evt_pkt_id) && $stable(evt_pkt_time);
  endproperty
  a_hold: assert property (p_hold) else $error("packet changed early");
  property p_gap;
    evt_pkt_valid && evt_pkt_ready |=> !evt_pkt_valid;
  endproperty
  a_gap: assert property (p_gap) else $error("no gap after packet");
  // only the nine event ids ever go out
  property p_id;
    evt_pkt_valid |-> evt_pkt_id inside {16'h8020, 16'h8021, 16'h8022, 16'h8030,
      16'h8031, 16'h8040, 16'h8041, 16'h9000, 16'h9100};
  endproperty
  a_id: assert property (p_id) else $error("bad packet id");
  property p_quiet;
    $rose(rst_n) |-> !evt_pkt_valid [*2];
  endproperty
  a_quiet: assert property (p_quiet) else $error("packet without event");
  // bus answers one cycle after a request, for one cycle
  property p_ack;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("late bus answer");
  property p_short;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_short: assert property (p_short) else $error("answer too long");
  property p_zero;
    avs_read && avs_waitrequest && (avs_address > OFS_DROP_STATUS ||
      avs_address == OFS_IRQ_CLEAR) |=> avs_readdata == UNMAPPED_READ;
  endproperty
  a_zero: assert property (p_zero) else $error("nonzero empty read");
  property p_sel;
    avs_read && avs_waitrequest && avs_address == OFS_SELECT |=> avs_readdata < 32'h9;
  endproperty
  a_sel: assert property (p_sel) else $error("selector out of range");
endmodule
bind camera_event_notifier camera_event_notifier_sva i_sva (.clk(clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .evt_pkt_valid(evt_pkt_valid), .evt_pkt_id(evt_pkt_id), .evt_pkt_time(evt_pkt_time),
  .evt_pkt_ready(evt_pkt_ready));
`default_nettype wire

// ---- tb/testbench.sv ----
// testbench: registers, events and packets of the camera event notifier
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import event_notifier_pkg::*;
  logic clk, rst_n, rd, wr, stall, irq, vld, rdy, wq;
  logic [8:0] ev;
  logic [7:0] adr, cnt, c;
  logic [3:0] be;
  logic [31:0] wd, rdat, d;
  logic [15:0] pid, gid;
  logic [63:0] ts, ptime, gtime, t;
  int mismatches, samples_checked;
  // type code beside the packet id it must carry
  logic [19:0] rows [9] = '{20'h08020, 20'h18021, 20'h28022, 20'h38030, 20'h48031,
    20'h58040, 20'h68041, 20'h79000, 20'h89100};
  camera_event_notifier i_dut (.clk(clk), .rst_n(rst_n), .timestamp(ts),
    .frame_start_accepted(ev[0]), .frame_start_rejected(ev[1]), .frame_start_waiting(ev[2]),
    .xfer_begin(ev[3]), .xfer_finish(ev[4]), .expose_begin(ev[5]), .expose_finish(ev[6]),
    .first_timer_begin(ev[7]), .first_timer_finish(ev[8]), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wq), .evt_pkt_valid(vld), .evt_pkt_id(pid),
    .evt_pkt_time(ptime), .evt_pkt_ready(rdy), .irq(irq));
  host_link_model i_host (.clk(clk), .rst_n(rst_n), .stall(stall), .evt_pkt_valid(vld),
    .evt_pkt_id(pid), .evt_pkt_time(ptime), .evt_pkt_ready(rdy), .got_count_ff(cnt),
    .got_id_ff(gid), .got_time_ff(gtime));
  task close_out;
    $display("checked %0d mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task give_up;
    mismatches++;
    close_out();
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one bus access, held until wait drops; read data lands in d
  task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    adr <= a;
    wd <= v;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wq !== 1'b0) begin
      n++;
      if (n > 40) give_up();
      @(posedge clk);
    end
    d = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task fire(input int i, input logic [63:0] tv);
    ts <= tv;
    ev <= 9'h001 << i;
    @(posedge clk);
    ev <= 9'h000;
    @(posedge clk);
  endtask
  task wait_pkt(input logic [7:0] c0);
    int n;
    n = 0;
    while (cnt === c0) begin
      n++;
      if (n > 40) give_up();
      @(posedge clk);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst_n, rd, wr, stall, ev, adr, wd, ts} = '0;
    be = 4'hf;
    mismatches = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // each row: select, enable, fire, then check packet and stored time
    for (int i = 0; i < 9; i++) begin
      t = 64'h0123456789ab0000 + 64'(i);
      bus(1, OFS_SELECT, {28'h0, rows[i][19:16]});
      bus(1, OFS_NOTIFY, 32'h1);
      c = cnt;
      fire(i, t);
      wait_pkt(c);
      chk(gid, rows[i][15:0]);
      chk(gtime, t);
      bus(0, OFS_TIME_LO, 0);
      chk(d, t[31:0]);
      bus(0, OFS_TIME_HI, 0);
      chk(d, t[63:32]);
    end
    $display("test event rows done");
    // masked, raised, then cleared interrupt
    chk(irq, 0);
    bus(0, OFS_IRQ_STATUS, 0);
    chk(d, 32'h1ff);
    bus(1, OFS_IRQ_ENABLE, 32'h20);
    repeat (2) @(posedge clk);
    chk(irq, 1);
    bus(1, OFS_IRQ_CLEAR, 32'h20);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    bus(0, OFS_IRQ_STATUS, 0);
    chk(d, 32'h1df);
    $display("test irq done");
    // second reset, then per-type enables and a stalled host
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(0, OFS_SELECT, 0);
    chk(d, 0);
    bus(0, OFS_NOTIFY, 0);
    chk(d, 0);
    bus(1, OFS_SELECT, 32'h2);
    bus(1, OFS_NOTIFY, 32'h1);
    bus(1, OFS_SELECT, 32'h3);
    bus(1, OFS_SELECT, 32'h9);
    bus(0, OFS_SELECT, 0);
    chk(d, 3);
    bus(0, OFS_NOTIFY, 0);
    chk(d, 0);
    c = cnt;
    fire(3, 64'h33);
    repeat (10) @(posedge clk);
    chk(cnt, c);
    stall <= 1'b1;
    fire(2, 64'h22);
    repeat (8) @(posedge clk);
    chk(cnt, c);
    chk(vld, 1);
    stall <= 1'b0;
    wait_pkt(c);
    chk(gid, 16'h8022);
    chk(gtime, 64'h22);
    be <= 4'h0;
    bus(1, OFS_SELECT, 32'h5);
    be <= 4'hf;
    bus(0, OFS_SELECT, 0);
    chk(d, 3);
    bus(0, 8'h20, 0);
    chk(d, 0);
    $display("test reset and selector done");
    // repeats of a pending type merge, set the overrun bit, last time wins
    stall <= 1'b1;
    fire(2, 64'h44);
    fire(2, 64'h55);
    fire(2, 64'h66);
    bus(0, OFS_DROP_STATUS, 0);
    chk(d, 32'h4);
    bus(1, OFS_DROP_STATUS, 32'h4);
    bus(0, OFS_DROP_STATUS, 0);
    chk(d, 0);
    c = cnt;
    stall <= 1'b0;
    wait_pkt(c);
    chk(gtime, 64'h44);
    chk(gid, 16'h8022);
    c = cnt;
    wait_pkt(c);
    chk(gtime, 64'h66);
    $display("test overrun done");
    close_out();
  end
endmodule
`default_nettype wire
